// >>> verilog/coddc_pkg.sv
// Package: object indices, field layouts, reset values and timing for the dictionary core
package coddc_pkg;
    // Object indices and sub-indices
    localparam logic [15:0] IDX_DEVICE_PROFILE_TYPE = 16'h1000;
    localparam logic [15:0] IDX_ERROR_SUMMARY = 16'h1001;
    localparam logic [15:0] IDX_ERROR_HISTORY = 16'h1003;
    localparam logic [15:0] IDX_SYNC_MESSAGE_IDENTIFIER = 16'h1005;
    localparam logic [15:0] IDX_SYNC_CYCLE_PERIOD = 16'h1006;
    localparam logic [7:0] SUB_COUNT = 8'h00;
    localparam logic [7:0] SUB_FIRST_ENTRY = 8'h01;
    // Error summary bit positions
    localparam int ERR_GENERIC = 0;
    localparam int ERR_CURRENT = 1;
    localparam int ERR_VOLTAGE = 2;
    localparam int ERR_TEMPERATURE = 3;
    localparam int ERR_COMMUNICATION = 4;
    localparam int ERR_PROFILE = 5;
    localparam int ERR_MAKER = 7;
    localparam logic [7:0] ERR_CATEGORY_MASK = 8'hBE;
    // History
    localparam int HISTORY_DEPTH = 4;
    localparam logic [31:0] HISTORY_COUNT_RESET = 32'h0000_0000;
    // Sync identifier: bit 30 activates the generator
    localparam int SYNC_GEN_BIT = 30;
    localparam logic [31:0] SYNC_ID_RESET = 32'h0000_0080;
    localparam logic [31:0] SYNC_PERIOD_RESET = 32'h0000_0000;
    // Sync period unit
    localparam int CLK_HZ = 10_000_000;
    localparam int SYNC_UNIT_NS = 125_000;
    localparam int SYNC_UNIT_CYCLES = SYNC_UNIT_NS / (1_000_000_000 / CLK_HZ);
    // Access answer codes
    localparam logic [1:0] ACK_OK = 2'h0;
    localparam logic [1:0] ACK_READ_ONLY = 2'h1;
    localparam logic [1:0] ACK_BAD_VALUE = 2'h2;
    localparam logic [1:0] ACK_NO_OBJECT = 2'h3;
endpackage

// >>> verilog/coddc_sync_gen.sv
// Periodic sync pulse generator counting 125 us units
`timescale 1ns/1ps
module coddc_sync_gen #(
    parameter int UNIT_CYCLES = coddc_pkg::SYNC_UNIT_CYCLES
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic enable,
    input wire logic [31:0] period_units,
    output logic sync_pulse
);
    localparam int UW = $clog2(UNIT_CYCLES + 1);
    logic [UW-1:0] unit_count;
    logic unit_tick;
    logic [31:0] period_count;
    logic running;

    // ==========================================
    // 125 us unit divider
    assign running = enable && (period_units != 32'h0000_0000);
    assign unit_tick = running && (unit_count == UW'(UNIT_CYCLES - 1));

    always_ff @(posedge clk) begin
        if (reset || !running || unit_tick) begin
            unit_count <= '0;
        end else begin
            unit_count <= unit_count + UW'(1);
        end
    end

    // ==========================================
    // Period counter
    always_ff @(posedge clk) begin
        if (reset || !running) begin
            period_count <= 32'h0000_0000;
            sync_pulse <= 1'b0;
        end else if (unit_tick) begin
            if (period_count >= period_units - 32'h0000_0001) begin
                period_count <= 32'h0000_0000;
                sync_pulse <= 1'b1; // RL5
            end else begin
                period_count <= period_count + 32'h0000_0001;
                sync_pulse <= 1'b0;
            end
        end else begin
            sync_pulse <= 1'b0;
        end
    end
endmodule

// >>> verilog/coddc_core.sv
// Communication object dictionary core: identity, error summary, history, sync
// Operation
// RL1: Read-only profile identification word at 1000.
// RL2: Fault sets its category bit; bit6 zero.
// RL3: Bit 0 set whenever any error present.
// RL4: History count 0..4; only zero write clears.
// RL5: Sync period counts 125us units.
// RL6: Sync generator stopped until identifier activates.
`timescale 1ns/1ps
module coddc_core #(
    parameter logic [31:0] PROFILE_TYPE = 32'h0000_0000, // Arbitrary value
    parameter int UNIT_CYCLES = coddc_pkg::SYNC_UNIT_CYCLES
) (
    input wire logic clk,
    input wire logic reset,
    // Object access port
    input wire logic req_valid,
    input wire logic req_write,
    input wire logic [15:0] req_index,
    input wire logic [7:0] req_subindex,
    input wire logic [31:0] req_wdata,
    output logic resp_valid,
    output logic [31:0] resp_rdata,
    output logic [1:0] resp_code,
    // Fault reporting from the drive
    input wire logic fault_valid,
    input wire logic [7:0] fault_category,
    input wire logic [31:0] fault_code,
    input wire logic fault_clear,
    // Sync generator output
    output logic sync_pulse,
    output logic sync_active
);
    logic [7:0] error_summary;
    logic [31:0] error_history_list [coddc_pkg::HISTORY_DEPTH];
    logic [2:0] history_count;
    logic [31:0] sync_message_identifier;
    logic [31:0] sync_cycle_period;
    logic wr_count;
    logic count_ok;
    logic [31:0] next_rdata;
    logic [1:0] next_code;
    int entry_sel;

    function automatic logic hit(input logic [15:0] idx, input logic [15:0] want);
        return idx == want;
    endfunction

    assign wr_count = req_valid && req_write && hit(req_index, coddc_pkg::IDX_ERROR_HISTORY)
        && req_subindex == coddc_pkg::SUB_COUNT;
    assign count_ok = req_wdata == 32'h0000_0000;
    assign entry_sel = int'(req_subindex) - int'(coddc_pkg::SUB_FIRST_ENTRY);

    // ==========================================
    // Error summary
    always_ff @(posedge clk) begin
        if (reset) begin
            error_summary <= 8'h00;
        end else if (fault_valid) begin
            // New fault wins over a same-cycle clear
            error_summary <= (fault_clear ? 8'h00 : error_summary)
                | (fault_category & coddc_pkg::ERR_CATEGORY_MASK)
                | 8'h01; // RL2 RL3
        end else if (fault_clear) begin
            error_summary <= 8'h00;
        end
    end

    // ==========================================
    // Error history, newest at entry 1
    always_ff @(posedge clk) begin
        if (reset) begin
            history_count <= 3'h0;
            for (int i = 0; i < coddc_pkg::HISTORY_DEPTH; i++) begin
                error_history_list[i] <= 32'h0000_0000;
            end
        end else if (fault_valid) begin
            // Logging beats a same-cycle clear so the fault is not lost
            for (int i = coddc_pkg::HISTORY_DEPTH - 1; i > 0; i--) begin
                error_history_list[i] <= error_history_list[i-1];
            end
            error_history_list[0] <= fault_code;
            if (wr_count && count_ok) begin
                history_count <= 3'h1;
            end else if (history_count < 3'(coddc_pkg::HISTORY_DEPTH)) begin
                history_count <= history_count + 3'h1; // RL4
            end
        end else if (wr_count && count_ok) begin
            history_count <= 3'h0; // RL4
        end
    end

    // ==========================================
    // Sync configuration
    always_ff @(posedge clk) begin
        if (reset) begin
            sync_message_identifier <= coddc_pkg::SYNC_ID_RESET;
            sync_cycle_period <= coddc_pkg::SYNC_PERIOD_RESET;
        end else if (req_valid && req_write) begin
            if (hit(req_index, coddc_pkg::IDX_SYNC_MESSAGE_IDENTIFIER)) begin
                sync_message_identifier <= req_wdata; // RL6
            end
            if (hit(req_index, coddc_pkg::IDX_SYNC_CYCLE_PERIOD)) begin
                sync_cycle_period <= req_wdata;
            end
        end
    end

    // Stays off until the identifier's generate bit is written
    assign sync_active = sync_message_identifier[coddc_pkg::SYNC_GEN_BIT]; // RL6

    coddc_sync_gen #(
        .UNIT_CYCLES(UNIT_CYCLES)
    ) u_sync (
        .clk(clk),
        .reset(reset),
        .enable(sync_active),
        .period_units(sync_cycle_period),
        .sync_pulse(sync_pulse)
    );

    // ==========================================
    // Access answer
    always_comb begin
        next_rdata = 32'h0000_0000;
        next_code = coddc_pkg::ACK_OK;
        unique case (req_index)
            coddc_pkg::IDX_DEVICE_PROFILE_TYPE: begin
                next_rdata = PROFILE_TYPE;
                if (req_write) begin
                    next_code = coddc_pkg::ACK_READ_ONLY; // RL1
                end
            end
            coddc_pkg::IDX_ERROR_SUMMARY: begin
                next_rdata = {24'h00_0000, error_summary};
                if (req_write) begin
                    next_code = coddc_pkg::ACK_READ_ONLY;
                end
            end
            coddc_pkg::IDX_ERROR_HISTORY: begin
                if (req_subindex == coddc_pkg::SUB_COUNT) begin
                    next_rdata = {29'h0000_0000, history_count};
                    if (req_write && !count_ok) begin
                        next_code = coddc_pkg::ACK_BAD_VALUE; // RL4
                    end
                end else if (entry_sel >= 0 && entry_sel < int'(history_count)) begin
                    next_rdata = error_history_list[entry_sel[1:0]];
                    if (req_write) begin
                        next_code = coddc_pkg::ACK_READ_ONLY;
                    end
                end else begin
                    next_code = coddc_pkg::ACK_NO_OBJECT;
                end
            end
            coddc_pkg::IDX_SYNC_MESSAGE_IDENTIFIER: begin
                next_rdata = sync_message_identifier;
            end
            coddc_pkg::IDX_SYNC_CYCLE_PERIOD: begin
                next_rdata = sync_cycle_period;
            end
            default: begin
                next_code = coddc_pkg::ACK_NO_OBJECT;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            resp_valid <= 1'b0;
            resp_rdata <= 32'h0000_0000;
            resp_code <= coddc_pkg::ACK_OK;
        end else begin
            resp_valid <= req_valid;
            if (req_valid) begin
                resp_rdata <= next_rdata;
                resp_code <= next_code;
            end
        end
    end
endmodule

// >>> tb/coddc_core_checker.sv
// Checker for the dictionary core ports
`timescale 1ns/1ps
module coddc_core_checker (
    input wire logic clk,
    input wire logic reset,
    input wire logic req_valid,
    input wire logic req_write,
    input wire logic [15:0] req_index,
    input wire logic [7:0] req_subindex,
    input wire logic [31:0] req_wdata,
    input wire logic resp_valid,
    input wire logic [31:0] resp_rdata,
    input wire logic [1:0] resp_code,
    input wire logic fault_valid,
    input wire logic [7:0] fault_category,
    input wire logic fault_clear,
    input wire logic sync_pulse,
    input wire logic sync_active
);
    // ====================
    // Properties
    default clocking @(posedge clk); endclocking
    default disable iff (reset);
    wire rd = req_valid && !req_write;
    wire cnt = req_index == 16'h1003 && req_subindex == 8'h00;
    // Requests come two cycles apart, so a fault is read back two edges later
    sequence s_flt; fault_valid && fault_category[3] ##1 !fault_clear; endsequence
    sequence s_rd_sum; rd && req_index == 16'h1001; endsequence
    sequence s_clr; req_valid && req_write && cnt && req_wdata == 0 && !fault_valid; endsequence
    sequence s_rd_cnt; rd && cnt && !fault_valid; endsequence
    property p_ans; req_valid |=> resp_valid; endproperty
    a_ans: assert property (p_ans) else $error("no answer");
    property p_quiet; !req_valid |=> !resp_valid; endproperty
    a_quiet: assert property (p_quiet) else $error("stray answer");
    property p_ro; req_valid && req_write && req_index == 16'h1000
        |=> resp_code == coddc_pkg::ACK_READ_ONLY; endproperty
    a_ro: assert property (p_ro) else $error("id write taken");
    property p_sum; s_flt ##1 s_rd_sum
        |=> resp_rdata[0] && resp_rdata[3] && !resp_rdata[6]; endproperty
    a_sum: assert property (p_sum) else $error("summary wrong");
    property p_gen; s_rd_sum
        |=> !resp_rdata[6] && (resp_rdata[0] || resp_rdata[7:1] == 7'h00); endproperty
    a_gen: assert property (p_gen) else $error("summary flag wrong");
    property p_bad; req_valid && req_write && cnt && req_wdata != 0
        |=> resp_code == coddc_pkg::ACK_BAD_VALUE; endproperty
    a_bad: assert property (p_bad) else $error("count write taken");
    property p_zero; s_clr ##1 !fault_valid ##1 s_rd_cnt |=> resp_rdata == 0; endproperty
    a_zero: assert property (p_zero) else $error("history kept");
    property p_max; rd && cnt |=> resp_rdata <= 4; endproperty
    a_max: assert property (p_max) else $error("count too big");
    property p_off; !sync_active && !$past(sync_active) |-> !sync_pulse; endproperty
    a_off: assert property (p_off) else $error("sync while off");
    property p_gap; sync_pulse |=> !sync_pulse [*3]; endproperty
    a_gap: assert property (p_gap) else $error("sync too soon");
endmodule
bind coddc_core coddc_core_checker coddc_core_checker_i (.*);

// >>> tb/coddc_master.sv
// Network master model issuing dictionary accesses
`timescale 1ns/1ps
module coddc_master (
    input wire logic clk,
    output logic req_valid,
    output logic req_write,
    output logic [15:0] req_index,
    output logic [7:0] req_subindex,
    output logic [31:0] req_wdata,
    input wire logic resp_valid,
    input wire logic [31:0] resp_rdata,
    input wire logic [1:0] resp_code
);
    // ====================
    // Access
    initial {req_valid, req_write, req_index, req_subindex, req_wdata} = '0;
    task access(input logic w, input logic [15:0] i, input logic [7:0] s,
            input logic [31:0] d, output logic [31:0] rd, output logic [1:0] c,
            output logic ok);
        @(posedge clk);
        req_valid <= 1'b1;
        req_write <= w;
        req_index <= i;
        req_subindex <= s;
        req_wdata <= d;
        @(posedge clk);
        req_valid <= 1'b0;
        // Released index, subindex and data show junk, not the last value; req_write keeps its last value
        req_index <= ~i;
        req_subindex <= ~s;
        req_wdata <= ~d;
        @(negedge clk);
        ok = resp_valid;
        rd = resp_rdata;
        c = resp_code;
    endtask
endmodule

// >>> tb/coddc_core_tb.sv
// Testbench for the dictionary core
`timescale 1ns/1ps
module coddc_core_tb;
    localparam logic [31:0] PROFILE_TYPE = 32'h0000_0123; // Arbitrary value
    localparam int UNIT_CYCLES = 4;
    logic clk = 1'b0, reset = 1'b1, req_valid, req_write, resp_valid, ok, sync_pulse;
    logic fault_valid = 1'b0, fault_clear = 1'b0, sync_active;
    logic [15:0] req_index;
    logic [7:0] req_subindex, fault_category = 8'h00, ex = 8'h00;
    logic [31:0] req_wdata, resp_rdata, fault_code = 32'h0, rd;
    logic [1:0] resp_code, code;
    logic [7:0] cats [6] = '{8'h02, 8'h08, 8'h10, 8'h20, 8'h80, 8'h40};
    int n_checks = 0, fail_count = 0, pulses = 0, since = 0, gap = 0;
    coddc_core #(.PROFILE_TYPE(PROFILE_TYPE), .UNIT_CYCLES(UNIT_CYCLES)) coddc_core_i (.*);
    coddc_master coddc_master_i (.*);
    initial forever #50 clk = ~clk;
    always @(negedge clk) begin
        since++;
        if (sync_pulse === 1'b1) begin
            pulses++;
            gap = since;
            since = 0;
        end
    end
    // ====================
    // Tasks
    task chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("BAD t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task acc(input logic w, input logic [15:0] i, input logic [7:0] s,
            input logic [31:0] d, input logic [31:0] ed, input logic [1:0] ec);
        coddc_master_i.access(w, i, s, d, rd, code, ok);
        chk({31'h0, ok}, 32'h1);
        chk({30'h0, code}, {30'h0, ec});
        if (!w) chk(rd, ed);
    endtask
    task pulse_fault(input logic v, input logic [7:0] cat, input logic [31:0] fc,
            input logic clr);
        @(posedge clk);
        fault_valid <= v;
        fault_category <= cat;
        fault_code <= fc;
        fault_clear <= clr;
        @(posedge clk);
        fault_valid <= 1'b0;
        fault_clear <= 1'b0;
    endtask
    task print_verdict;
        $display("checks %0d errors %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    initial begin
        repeat (5000) @(posedge clk);
        fail_count++;
        print_verdict;
    end
    // ====================
    // Tests
    initial begin
        repeat (12) @(posedge clk);
        reset <= 1'b0;
        acc(0, 16'h1001, 0, 0, 0, 0);
        acc(0, 16'h1005, 0, 0, 32'h80, 0);
        acc(1, 16'h1000, 0, 32'h5, 0, 1);
        acc(0, 16'h1000, 0, 0, PROFILE_TYPE, 0);
        acc(1, 16'h1001, 0, 32'hFF, 0, 1);
        acc(0, 16'h1002, 0, 0, 0, 3);
        for (int i = 0; i < 6; i++) begin
            pulse_fault(1, cats[i], 32'h100 + i, 0);
            ex = ex | (cats[i] & 8'hBE) | 8'h01;
            acc(0, 16'h1001, 0, 0, {24'h0, ex}, 0);
            acc(0, 16'h1003, 0, 0, (i < 4) ? i + 1 : 4, 0);
            acc(0, 16'h1003, 1, 0, 32'h100 + i, 0);
        end
        acc(0, 16'h1003, 4, 0, 32'h102, 0);
        acc(1, 16'h1003, 0, 32'h4, 0, 2);
        acc(0, 16'h1003, 0, 0, 4, 0);
        acc(1, 16'h1003, 0, 0, 0, 0);
        acc(0, 16'h1003, 0, 0, 0, 0);
        acc(0, 16'h1003, 1, 0, 0, 3);
        // Fault in the same cycle as a count-zero write is kept
        fork
            pulse_fault(1, 8'h02, 32'h200, 0);
            acc(1, 16'h1003, 0, 0, 0, 0);
        join
        acc(0, 16'h1003, 0, 0, 1, 0);
        acc(0, 16'h1003, 1, 0, 32'h200, 0);
        acc(1, 16'h1003, 1, 32'h55, 0, 1);
        acc(0, 16'h1003, 1, 0, 32'h200, 0);
        pulse_fault(1, 8'h10, 32'h201, 1);
        acc(0, 16'h1001, 0, 0, 32'h11, 0);
        pulse_fault(0, 8'h00, 32'h0, 1);
        acc(0, 16'h1001, 0, 0, 0, 0);
        chk(pulses, 0);
        acc(1, 16'h1006, 0, 32'h2, 0, 0);
        acc(0, 16'h1006, 0, 0, 32'h2, 0);
        acc(1, 16'h1005, 0, 32'h4000_0080, 0, 0);
        chk({31'h0, sync_active}, 32'h1);
        pulses = 0;
        repeat (40) @(posedge clk);
        chk(gap, 2 * UNIT_CYCLES);
        chk(pulses > 3, 1);
        acc(1, 16'h1005, 0, 32'h80, 0, 0);
        // Let a pulse launched with the write drain before counting
        @(posedge clk);
        pulses = 0;
        repeat (40) @(posedge clk);
        chk(pulses, 0);
        // Mid-run reset brings summary, history count and both sync entries back to their reset values
        pulse_fault(1, 8'h20, 32'h300, 0);
        @(posedge clk);
        reset <= 1'b1;
        repeat (2) @(posedge clk);
        reset <= 1'b0;
        acc(0, 16'h1001, 0, 0, 0, 0);
        acc(0, 16'h1003, 0, 0, 0, 0);
        acc(0, 16'h1005, 0, 0, 32'h80, 0);
        acc(0, 16'h1006, 0, 0, 0, 0);
        chk({31'h0, sync_active}, 32'h0);
        print_verdict;
    end
endmodule
